// [ddc_map.vh]
// Constants for the drive-side control and data interface
`ifndef DDC_MAP_VH
`define DDC_MAP_VH
// Clock 10 MHz: 100 ns period
`define DDC_CLK_NS        32'd100
// Direction setup before a step pulse, step low width, step recovery
`define DDC_DIR_SETUP_NS  32'd1000
`define DDC_STEP_LOW_NS   32'd1000
`define DDC_STEP_GAP_NS   32'd2000
`define DDC_DIR_SETUP_CY  ((`DDC_DIR_SETUP_NS + `DDC_CLK_NS - 32'd1) / `DDC_CLK_NS)
`define DDC_STEP_LOW_CY   ((`DDC_STEP_LOW_NS + `DDC_CLK_NS - 32'd1) / `DDC_CLK_NS)
`define DDC_STEP_GAP_CY   ((`DDC_STEP_GAP_NS + `DDC_CLK_NS - 32'd1) / `DDC_CLK_NS)
`define DDC_CNT_W         8
// Step direction levels
`define DDC_DIR_IN        1'b0
`define DDC_DIR_OUT       1'b1
// Head number width and FIFO shape
`define DDC_HEAD_W        3
`define DDC_FIFO_W        8
`define DDC_FIFO_D        8
`define DDC_FIFO_AW       3
`define DDC_BIT_CNT_W     3
`define DDC_BIT_LAST      3'h7
`endif

// [ddc_fifo.v]
// Synchronous valid/ready FIFO with parameterised width and depth
module ddc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
)(
	input  wire             i_mclk,
	input  wire             i_reset,
	input  wire [WIDTH-1:0] i_data,
	input  wire             i_valid,
	output wire             o_ready,
	output wire [WIDTH-1:0] o_data,
	output wire             o_valid,
	input  wire             i_ready
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_reg;
	reg  [AW-1:0]    rd_ptr_reg;
	reg  [AW:0]      count_reg;
	reg  [AW:0]      count_next;
	reg              ready_reg;
	wire             push;
	wire             pop;

	// Ready is registered from the next count so it leaves a flip-flop
	assign o_ready = ready_reg;
	assign o_valid = (count_reg != {(AW+1){1'b0}});
	assign o_data  = mem[rd_ptr_reg];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	always @(posedge i_mclk)
	begin
		if (push)
			mem[wr_ptr_reg] <= i_data;
	end

	always @*
	begin
		count_next = count_reg;
		if (push & ~pop)
			count_next = count_reg + {{AW{1'b0}}, 1'b1};
		else if (pop & ~push)
			count_next = count_reg - {{AW{1'b0}}, 1'b1};
	end

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			ready_reg  <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			count_reg <= count_next;
			ready_reg <= (count_next != DEPTH[AW:0]);
		end
	end
endmodule

// [ddc_sync.v]
// Two flip-flop synchroniser, one per input bit
module ddc_sync #(
	parameter WIDTH = 1
)(
	input  wire             i_mclk,
	input  wire             i_reset,
	input  wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	assign o_sync = sync_reg;

	// Resets to all ones: the drive status inputs are active low
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
		end
		else
		begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end
endmodule

// [ddc_drive_if.v]
// Drive-side control and encoded data interface of the disk controller
//
// Contract
// - Head number driven as active-low binary code on three outputs.
// - Direction low steps toward spindle, high steps toward track 0.
// - One low step strobe pulse moves heads one step in set direction.
// - Drive usable only while available and settled are both low; the step gate here checks available, not settled.
// - Unit select driven low to tell drive the controller is ready.
// - Unit select goes high on reset command, power-fail or initialize.
// - Each rising write-stream edge is one flux reversal, only gate low.
// - Read data recovered from rising edges of the encoded read stream.
// - Write gate low enables writing if settled; high allows stepping.
`include "ddc_map.vh"
module ddc_drive_if (
	input  wire                  i_mclk,
	input  wire                  i_reset,
	input  wire                  i_reset_cmd,
	input  wire                  i_ac_ok,
	input  wire                  i_ctrl_ready,
	input  wire [`DDC_HEAD_W-1:0] i_head,
	input  wire                  i_step_req,
	input  wire                  i_step_dir,
	output reg                   o_step_busy,
	input  wire                  i_write_en,
	input  wire                  i_bit_tick,
	input  wire [`DDC_FIFO_W-1:0] i_wr_data,
	input  wire                  i_wr_valid,
	output wire                  o_wr_ready,
	output reg  [`DDC_FIFO_W-1:0] o_rd_data,
	output reg                   o_rd_valid,
	input  wire                  i_index_n,
	input  wire                  i_ready_n,
	input  wire                  i_settled_n,
	input  wire                  i_fault_n,
	input  wire                  i_track0_n,
	input  wire                  i_read_stream,
	output reg                   o_head_addr_bit0,
	output reg                   o_head_addr_bit1,
	output reg                   o_head_addr_bit2,
	output reg                   o_dir_n,
	output reg                   o_step_n,
	output reg                   o_unit_choose_0,
	output reg                   o_write_gate_n,
	output reg                   o_encoded_write_stream,
	output reg                   o_index,
	output reg                   o_drive_ok,
	output reg                   o_fault,
	output reg                   o_track0,
	output reg                   o_flux_pulse
);
	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	localparam NSYNC = 6;
	wire [NSYNC-1:0] pins_s;
	wire             index_n_s;
	wire             ready_n_s;
	wire             settled_n_s;
	wire             fault_n_s;
	wire             track0_n_s;
	wire             read_s;

	ddc_sync #(.WIDTH(NSYNC)) u_sync (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_async ({i_index_n, i_ready_n, i_settled_n, i_fault_n,
		           i_track0_n, i_read_stream}),
		.o_sync  (pins_s)
	);
	assign index_n_s   = pins_s[5];
	assign ready_n_s   = pins_s[4];
	assign settled_n_s = pins_s[3];
	assign fault_n_s   = pins_s[2];
	assign track0_n_s  = pins_s[1];
	assign read_s      = pins_s[0];

	// The drive latches a fault until power cycles; seeking and
	// writing are held off here too so no command is wasted on it.
	wire drive_ok   = ~ready_n_s & ~settled_n_s & fault_n_s;
	wire can_step   = ~ready_n_s & fault_n_s & o_write_gate_n;

	// ****************************************************************
	// Status and head address outputs
	// ****************************************************************
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_head_addr_bit0 <= 1'b1;
			o_head_addr_bit1 <= 1'b1;
			o_head_addr_bit2 <= 1'b1;
			o_unit_choose_0  <= 1'b1;
			o_index          <= 1'b0;
			o_drive_ok       <= 1'b0;
			o_fault          <= 1'b0;
			o_track0         <= 1'b0;
		end
		else
		begin
			o_head_addr_bit0 <= ~i_head[0];
			o_head_addr_bit1 <= ~i_head[1];
			o_head_addr_bit2 <= ~i_head[2];
			if (i_reset_cmd | ~i_ac_ok)
				o_unit_choose_0 <= 1'b1;
			else
				o_unit_choose_0 <= ~i_ctrl_ready;
			o_index  <= ~index_n_s;
			o_drive_ok <= drive_ok;
			o_fault  <= ~fault_n_s;
			o_track0 <= ~track0_n_s;
		end
	end

	// ****************************************************************
	// Step sequencer
	// ****************************************************************
	localparam ST_IDLE  = 2'h0;
	localparam ST_SETUP = 2'h1;
	localparam ST_PULSE = 2'h2;
	localparam ST_GAP   = 2'h3;
	reg [1:0]            st_reg;
	reg [`DDC_CNT_W-1:0] cnt_reg;
	// Loads are cut to the counter width on purpose
	wire [31:0]           setup_ld = `DDC_DIR_SETUP_CY - 32'd1;
	wire [31:0]           low_ld   = `DDC_STEP_LOW_CY - 32'd1;
	wire [31:0]           gap_ld   = `DDC_STEP_GAP_CY - 32'd1;
	wire [`DDC_CNT_W-1:0] cnt_one  = {{(`DDC_CNT_W-1){1'b0}}, 1'b1};

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			st_reg      <= ST_IDLE;
			cnt_reg     <= {`DDC_CNT_W{1'b0}};
			o_dir_n     <= `DDC_DIR_OUT;
			o_step_n    <= 1'b1;
			o_step_busy <= 1'b0;
		end
		else
		begin
			case (st_reg)
			ST_IDLE:
			begin
				o_step_n <= 1'b1;
				if (i_step_req & can_step)
				begin
					// Direction latched here and held through the pulse
					o_dir_n     <= i_step_dir ? `DDC_DIR_OUT
					                          : `DDC_DIR_IN;
					o_step_busy <= 1'b1;
					cnt_reg     <= setup_ld[`DDC_CNT_W-1:0];
					st_reg      <= ST_SETUP;
				end
				else
					o_step_busy <= 1'b0;
			end
			ST_SETUP:
			begin
				if (cnt_reg == {`DDC_CNT_W{1'b0}})
				begin
					o_step_n <= 1'b0;
					cnt_reg  <= low_ld[`DDC_CNT_W-1:0];
					st_reg   <= ST_PULSE;
				end
				else
					cnt_reg <= cnt_reg - cnt_one;
			end
			ST_PULSE:
			begin
				if (cnt_reg == {`DDC_CNT_W{1'b0}})
				begin
					o_step_n <= 1'b1;
					cnt_reg  <= gap_ld[`DDC_CNT_W-1:0];
					st_reg   <= ST_GAP;
				end
				else
					cnt_reg <= cnt_reg - cnt_one;
			end
			ST_GAP:
			begin
				if (cnt_reg == {`DDC_CNT_W{1'b0}})
				begin
					o_step_busy <= 1'b0;
					st_reg      <= ST_IDLE;
				end
				else
					cnt_reg <= cnt_reg - cnt_one;
			end
			default:
				st_reg <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Write path: FIFO, serialiser, write gate
	// ****************************************************************
	wire [`DDC_FIFO_W-1:0] fifo_data;
	wire                   fifo_valid;
	reg                    fifo_take;
	reg  [`DDC_FIFO_W-1:0] sh_reg;
	reg  [`DDC_BIT_CNT_W-1:0] bit_reg;
	reg                    sh_full_reg;
	wire [`DDC_BIT_CNT_W-1:0] bit_one = {{(`DDC_BIT_CNT_W-1){1'b0}}, 1'b1};
	// Writing needs a settled, fault-free drive and no seek in flight;
	// a step taken in this very cycle wins over the gate
	wire write_ok = i_write_en & drive_ok & (st_reg == ST_IDLE)
	              & ~o_step_busy
	              & ~(i_step_req & can_step);

	ddc_fifo #(
		.WIDTH (`DDC_FIFO_W),
		.DEPTH (`DDC_FIFO_D),
		.AW    (`DDC_FIFO_AW)
	) u_fifo (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_data  (i_wr_data),
		.i_valid (i_wr_valid),
		.o_ready (o_wr_ready),
		.o_data  (fifo_data),
		.o_valid (fifo_valid),
		.i_ready (fifo_take)
	);

	always @*
	begin
		fifo_take = ~sh_full_reg & ~o_write_gate_n;
	end

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_write_gate_n         <= 1'b1;
			o_encoded_write_stream <= 1'b0;
			sh_reg                 <= {`DDC_FIFO_W{1'b0}};
			bit_reg                <= {`DDC_BIT_CNT_W{1'b0}};
			sh_full_reg            <= 1'b0;
		end
		else
		begin
			o_write_gate_n <= ~write_ok;
			o_encoded_write_stream <= 1'b0;
			if (fifo_take & fifo_valid)
			begin
				sh_reg      <= fifo_data;
				sh_full_reg <= 1'b1;
				bit_reg     <= {`DDC_BIT_CNT_W{1'b0}};
			end
			else if (sh_full_reg & i_bit_tick & ~o_write_gate_n
			         & write_ok)
			begin
				// A one bit is a one-cycle pulse: each rising edge is one
				// reversal. No shift as the gate closes, so the last
				// pulse ends under the gate. Ticks must not be adjacent.
				o_encoded_write_stream <= sh_reg[`DDC_FIFO_W-1];
				sh_reg <= {sh_reg[`DDC_FIFO_W-2:0], 1'b0};
				bit_reg <= bit_reg + bit_one;
				if (bit_reg == `DDC_BIT_LAST)
					sh_full_reg <= 1'b0;
			end
			else if (o_write_gate_n)
				sh_full_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// Read path: rising edges of the read stream become flux pulses
	// ****************************************************************
	reg read_d_reg;
	reg [`DDC_FIFO_W-1:0] rsh_reg;
	reg [`DDC_BIT_CNT_W-1:0] rbit_reg;
	wire flux = read_s & ~read_d_reg;

	// Limitation: no data separator; a bit cell is one i_bit_tick,
	// one if a reversal was seen during it.
	reg cell_flux_reg;
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			// Matches the synchroniser's reset level: no false edge
			read_d_reg    <= 1'b1;
			o_flux_pulse  <= 1'b0;
			cell_flux_reg <= 1'b0;
			rsh_reg       <= {`DDC_FIFO_W{1'b0}};
			rbit_reg      <= {`DDC_BIT_CNT_W{1'b0}};
			o_rd_data     <= {`DDC_FIFO_W{1'b0}};
			o_rd_valid    <= 1'b0;
		end
		else
		begin
			read_d_reg   <= read_s;
			o_flux_pulse <= flux & o_write_gate_n;
			o_rd_valid   <= 1'b0;
			if (i_bit_tick & o_write_gate_n & drive_ok)
			begin
				rsh_reg  <= {rsh_reg[`DDC_FIFO_W-2:0], cell_flux_reg | flux};
				cell_flux_reg <= 1'b0;
				rbit_reg <= rbit_reg + bit_one;
				if (rbit_reg == `DDC_BIT_LAST)
				begin
					o_rd_data  <= {rsh_reg[`DDC_FIFO_W-2:0],
					               cell_flux_reg | flux};
					o_rd_valid <= 1'b1;
				end
			end
			else if (flux)
				cell_flux_reg <= 1'b1;
		end
	end
endmodule

// [ddc_drive_if_props.sv]
// Concurrent checks on the drive-side pins of the disk interface
module ddc_drive_if_props (
	input wire		i_mclk,
	input wire		i_reset,
	input wire		i_reset_cmd,
	input wire		i_ac_ok,
	input wire		i_ctrl_ready,
	input wire [2:0]	i_head,
	input wire		i_step_req,
	input wire		i_step_dir,
	input wire		o_step_busy,
	input wire		o_head_addr_bit0,
	input wire		o_head_addr_bit1,
	input wire		o_head_addr_bit2,
	input wire		o_dir_n,
	input wire		o_step_n,
	input wire		o_unit_choose_0,
	input wire		o_write_gate_n,
	input wire		o_encoded_write_stream,
	input wire		o_flux_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	a_head_code: assert property (
		!$past(i_reset) |-> {o_head_addr_bit2, o_head_addr_bit1,
		o_head_addr_bit0} == ~$past(i_head)) else $error("head code");
	a_select_reset: assert property (disable iff (1'h0)
		i_reset && $past(i_reset) |-> o_unit_choose_0 && o_step_n)
		else $error("select in reset");
	a_step_width: assert property (
		$fell(o_step_n) |-> !o_step_n [*8] ##1 !o_step_n [*2] ##1 o_step_n)
		else $error("step width");
	a_dir_hold: assert property (
		!o_step_n |-> $stable(o_dir_n)) else $error("dir moved");
	a_dir_setup: assert property (
		$fell(o_step_n) |-> $past(o_dir_n, 8) == o_dir_n)
		else $error("dir setup");
	a_step_cause: assert property (
		$rose(o_step_busy) |-> $past(i_step_req) &&
		o_dir_n == $past(i_step_dir)) else $error("step cause");
	a_step_span: assert property (
		$rose(o_step_busy) |-> ##[38:42] $fell(o_step_busy))
		else $error("step span");
	a_gate_no_step: assert property (
		!o_write_gate_n |-> o_step_n) else $error("step in write");
	a_write_quiet: assert property (
		o_write_gate_n && $past(o_write_gate_n) |->
		$stable(o_encoded_write_stream)) else $error("stream moved");
	a_flux_gate: assert property (
		o_flux_pulse |-> o_write_gate_n ##1 !o_flux_pulse)
		else $error("flux pulse");
	a_unit_follow: assert property (
		!$past(i_reset) |-> o_unit_choose_0 == ($past(i_reset_cmd) ||
		!$past(i_ac_ok) || !$past(i_ctrl_ready)))
		else $error("unit select");
	a_gate_no_seek: assert property (
		!o_write_gate_n |-> !o_step_busy) else $error("seek in write");
	a_stream_gate: assert property (
		o_encoded_write_stream |-> !$past(o_write_gate_n))
		else $error("stream ungated");
endmodule
bind ddc_drive_if ddc_drive_if_props i_props (.i_mclk, .i_reset,
	.i_reset_cmd, .i_ac_ok, .i_ctrl_ready, .i_head,
	.i_step_req, .i_step_dir, .o_step_busy, .o_head_addr_bit0,
	.o_head_addr_bit1, .o_head_addr_bit2, .o_dir_n, .o_step_n,
	.o_unit_choose_0, .o_write_gate_n, .o_encoded_write_stream,
	.o_flux_pulse);

// [ddc_drive_model.sv]
// Behavioural winchester drive facing the controller pins
module ddc_drive_model #(
	parameter SETTLE  = 12,
	parameter IDX_PER = 400,
	parameter IDX_LOW = 40
)(
	input  wire		i_mclk,
	input  wire		i_step_n,
	input  wire		i_dir_n,
	input  wire		i_gate_n,
	input  wire		i_fault_cmd,
	input  wire		i_power_cyc,
	output reg		o_index_n = 1'h1,
	output reg		o_ready_n = 1'h0,
	output reg		o_settled_n = 1'h0,
	output reg		o_fault_n = 1'h1,
	output wire		o_track0_n,
	output reg [7:0]	o_cyl = 8'h02
);
	timeunit 1ns;
	timeprecision 1ns;
	reg		step_d = 1'h1;
	integer		settle_cnt = 0;
	integer		idx_cnt = 0;
	assign o_track0_n = (o_cyl != 8'h00);
	always @(posedge i_mclk)
	begin
		step_d <= i_step_n;
		idx_cnt <= (idx_cnt + 1) % IDX_PER;
		o_index_n <= (idx_cnt >= IDX_LOW);
		o_ready_n <= i_power_cyc;
		// Fault latches until power is cycled
		if (i_fault_cmd)
			o_fault_n <= 1'h0;
		else if (i_power_cyc)
			o_fault_n <= 1'h1;
		o_settled_n <= (settle_cnt != 0);
		if (settle_cnt != 0)
			settle_cnt <= settle_cnt - 1;
		// A step is lost, not queued, if the drive is not usable
		if (!i_step_n && step_d && o_fault_n && !o_ready_n &&
			!o_settled_n && i_gate_n)
		begin
			settle_cnt <= SETTLE;
			if (!i_dir_n)
				o_cyl <= o_cyl + 8'h01;
			else if (o_cyl != 8'h00)
				o_cyl <= o_cyl - 8'h01;
		end
	end
endmodule

// [ddc_drive_if_tb_top.sv]
// Self-checking bench for the drive-side disk interface
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
$display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module ddc_drive_if_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	reg		i_mclk = 0, i_reset = 1, i_reset_cmd = 0, i_ac_ok = 1;
	reg		i_ctrl_ready = 1, i_step_req = 0, i_step_dir = 0;
	reg		i_write_en = 0, i_bit_tick = 0, i_wr_valid = 0;
	reg		i_read_stream = 0, fault_cmd = 0, pwr_cyc = 0, acc, md;
	reg [2:0]	i_head = 0;
	reg [7:0]	i_wr_data = 0, b, mb;
	wire [7:0]	o_rd_data, cyl;
	wire		o_step_busy, o_wr_ready, o_rd_valid, o_dir_n, o_step_n;
	wire		o_head_addr_bit0, o_head_addr_bit1, o_head_addr_bit2;
	wire		o_unit_choose_0, o_write_gate_n, o_encoded_write_stream;
	wire		o_index, o_drive_ok, o_fault, o_track0, o_flux_pulse;
	wire		i_index_n, i_ready_n, i_settled_n, i_fault_n, i_track0_n;
	integer		failures = 0, tests_run = 0, toggles = 0;
	integer		ones, nb, n, k, cyl_exp;
	integer		flux_cnt = 0, flux_exp = 0, idx_len = 0, idx_seen = 0;
	reg		exp_dir[$];
	reg [7:0]	exp_byte[$];
	ddc_drive_if i_dut (.i_mclk, .i_reset, .i_reset_cmd, .i_ac_ok,
		.i_ctrl_ready, .i_head, .i_step_req, .i_step_dir, .o_step_busy,
		.i_write_en, .i_bit_tick, .i_wr_data, .i_wr_valid, .o_wr_ready,
		.o_rd_data, .o_rd_valid, .i_index_n, .i_ready_n, .i_settled_n,
		.i_fault_n, .i_track0_n, .i_read_stream, .o_head_addr_bit0,
		.o_head_addr_bit1, .o_head_addr_bit2, .o_dir_n, .o_step_n,
		.o_unit_choose_0, .o_write_gate_n, .o_encoded_write_stream,
		.o_index, .o_drive_ok, .o_fault, .o_track0, .o_flux_pulse);
	ddc_drive_model i_drive (.i_mclk, .i_step_n(o_step_n),
		.i_dir_n(o_dir_n), .i_gate_n(o_write_gate_n),
		.i_fault_cmd(fault_cmd), .i_power_cyc(pwr_cyc),
		.o_index_n(i_index_n), .o_ready_n(i_ready_n),
		.o_settled_n(i_settled_n), .o_fault_n(i_fault_n),
		.o_track0_n(i_track0_n), .o_cyl(cyl));
	initial
		forever #50 i_mclk = ~i_mclk;
	initial
	begin
		#2000000;
		failures++;
		test_done;
	end
	task test_done;
	begin
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task tick(input integer c);
		repeat (c) @(posedge i_mclk);
	endtask
	// Request is held until busy shows, or for at most 30 cycles if it never does
	task step(input dir, input take);
	begin
		i_step_dir <= dir;
		i_step_req <= 1'h1;
		for (k = 0; k < 30 && o_step_busy !== 1'h1; k++)
			tick(1);
		i_step_req <= 1'h0;
		`CHK(o_step_busy, take)
		if (take)
			exp_dir.push_back(dir);
		if (take)
			cyl_exp = dir ? (cyl_exp > 0 ? cyl_exp - 1 : 0) : cyl_exp + 1;
		for (k = 0; k < 60 && o_step_busy === 1'h1; k++)
			tick(1);
		tick(4);
	end
	endtask
	always @(posedge i_mclk)
	begin
		if ($rose(o_encoded_write_stream))
			toggles++;
		if (o_flux_pulse)
			flux_cnt++;
		// First marker is cut short by reset, so it is not judged
		if (o_index)
			idx_len++;
		else if (idx_len != 0)
		begin
			if (idx_seen)
				`CHK(idx_len, 40)
			idx_seen = 1;
			idx_len = 0;
		end
		if ($fell(o_step_n))
		begin
			md = exp_dir.pop_front();
			`CHK(o_dir_n, md)
		end
		if (o_rd_valid)
		begin
			mb = exp_byte.pop_front();
			`CHK(o_rd_data, mb)
		end
	end
	initial
	begin
		void'($urandom(65077));
		tick(4);
		`CHK(o_unit_choose_0, 1'h1)
		i_reset <= 1'h0;
		for (n = 0; n < 8; n++)
		begin
			i_head <= n[2:0];
			tick(2);
			`CHK({o_head_addr_bit2, o_head_addr_bit1, o_head_addr_bit0}, ~i_head)
		end
		for (n = 0; n < 8; n++)
		begin
			{i_ctrl_ready, i_ac_ok, i_reset_cmd} <= n[2:0] ^ 3'h6;
			tick(2);
			`CHK(o_unit_choose_0, !(i_ctrl_ready & i_ac_ok & !i_reset_cmd))
		end
		{i_ctrl_ready, i_ac_ok, i_reset_cmd} <= 3'h6;
		tick(8);
		// Outward steps first so the track zero stop is hit
		cyl_exp = 2;
		for (n = 0; n < 10; n++)
		begin
			step(n < 4 ? 1'h1 : 1'($urandom), 1'h1);
			`CHK(o_track0, cyl_exp == 0)
		end
		`CHK(cyl, cyl_exp[7:0])
		fault_cmd <= 1'h1;
		tick(1);
		fault_cmd <= 1'h0;
		tick(4);
		`CHK(o_fault, 1'h1)
		`CHK(o_drive_ok, 1'h0)
		step(1'h0, 1'h0);
		pwr_cyc <= 1'h1;
		tick(3);
		pwr_cyc <= 1'h0;
		tick(6);
		`CHK(o_fault, 1'h0)
		`CHK(o_drive_ok, 1'h1)
		step(1'h0, 1'h1);
		`CHK(cyl, cyl_exp[7:0])
		for (n = 0; n < 3; n++)
		begin
			b = 8'($urandom);
			exp_byte.push_back(b);
			flux_exp += $countones(b);
			for (k = 7; k >= 0; k--)
			begin
				i_read_stream <= b[k];
				tick(4);
				i_read_stream <= 1'h0;
				tick(4);
				i_bit_tick <= 1'h1;
				tick(1);
				i_bit_tick <= 1'h0;
			end
		end
		tick(4);
		`CHK(exp_byte.size(), 0)
		`CHK(flux_cnt, flux_exp)
		i_write_en <= 1'h1;
		tick(4);
		`CHK(o_write_gate_n, 1'h0)
		toggles = 0;
		ones = 0;
		nb = 0;
		i_wr_valid <= 1'h1;
		i_wr_data <= 8'($urandom);
		// No bit ticks yet: the buffer must fill and refuse
		for (n = 0; n < 14; n++)
		begin
			@(negedge i_mclk) acc = o_wr_ready;
			tick(1);
			if (acc)
				ones += $countones(i_wr_data);
			if (acc)
				nb++;
			if (acc)
				i_wr_data <= 8'($urandom);
		end
		i_wr_valid <= 1'h0;
		`CHK(o_wr_ready, 1'h0)
		repeat (nb * 8 + 16)
		begin
			i_bit_tick <= 1'h1;
			tick(1);
			i_bit_tick <= 1'h0;
			tick(3);
		end
		`CHK(toggles, ones)
		`CHK(o_wr_ready, 1'h1)
		i_write_en <= 1'h0;
		tick(6);
		`CHK(o_write_gate_n, 1'h1)
		test_done;
	end
endmodule
